/* File: bench/rsf_link_tx_model.sv */
// Behavioural model of the far-end link transmitter.
`timescale 1ns/100ps
module rsf_link_tx_model (
    // Control from the bench.
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic bad_crc_i,
    input wire logic [11:0] half_tenth_i,
    // Link pins.
    output logic link_clk_o,
    output logic [7:0] link_data_o
);
    int pos;
    logic [7:0] cnt;
    logic [7:0] chk;
    logic clr;

    // A reset marks the counters for restart at the next bit-time.
    always @(negedge rstn_i) clr = 1'b1;

    // Clock stands low outside frames; half period is in 100 ps units.
    initial begin
        link_clk_o = 1'b0;
        link_data_o = 8'h00;
        clr = 1'b1;
        forever begin
            wait (run_i === 1'b1 && rstn_i === 1'b1);
            if (clr) begin
                pos = 0;
                cnt = 8'h00;
                chk = 8'h00;
                clr = 1'b0;
            end
            if (pos < 512) begin
                link_data_o = cnt;
                chk = chk ^ cnt;
                cnt = cnt + 8'h01;
            end else if (pos == 512) begin
                link_data_o = chk ^ {8{bad_crc_i}};
                chk = 8'h00;
            end
            #(half_tenth_i * 0.1) link_clk_o = 1'b1;
            #(half_tenth_i * 0.1) link_clk_o = 1'b0;
            // Data is not held past the bit, so stale values never pass.
            link_data_o = ~link_data_o;
            pos = (pos + 1) % 516;
        end
    end
endmodule

/* File: bench/tb_rsf_sync_fifo.sv */
// Self-checking testbench for the receive synchronizing FIFO.
`timescale 1ns/100ps
module tb_rsf_sync_fifo;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic err_clr_i = 1'b0;
    logic run = 1'b0;
    logic bad = 1'b0;
    logic chk_on = 1'b0;
    logic [11:0] half = 12'h7D0;
    logic link_clk;
    logic [7:0] link_data;
    logic [7:0] data_o;
    logic [7:0] exp_d = 8'h00;
    logic valid_o, ovf_o, udf_o, crc_err_o;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;

    // Core clock at 20 MHz.
    initial forever #25 ref_clk_i = ~ref_clk_i;

    rsf_sync_fifo dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link_clk_i(link_clk),
        .link_data_i(link_data), .err_clr_i(err_clr_i), .data_o(data_o), .valid_o(valid_o),
        .ovf_o(ovf_o), .udf_o(udf_o), .crc_err_o(crc_err_o));

    rsf_link_tx_model mdl (.rstn_i(rstn_i), .run_i(run), .bad_crc_i(bad),
        .half_tenth_i(half), .link_clk_o(link_clk), .link_data_o(link_data));

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        comparisons++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Ends at a falling edge so that registered outputs have settled.
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask

    // Every word read while chk_on is set must be the next one sent; also cuts a hang short.
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            err_total++;
            print_verdict();
        end else if (!rstn_i) begin
            exp_d <= 8'h00;
        end else if (chk_on && valid_o === 1'b1) begin
            check(data_o, exp_d);
            exp_d <= exp_d + 8'h01;
        end
    end

    // Link stops in the same cycle as reset, so the model restarts at bit-time 0.
    task automatic do_reset(input logic [11:0] h);
        @(posedge ref_clk_i);
        run <= 1'b0;
        chk_on <= 1'b0;
        rstn_i <= 1'b0;
        half <= h;
        repeat (8) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
    endtask

    // Two CRC periods at one link rate, then the link stops and the FIFO drains.
    task automatic t_stream(input logic [11:0] h);
        do_reset(h);
        chk_on <= 1'b1;
        run <= 1'b1;
        wait_cyc(8300);
        check(8'(ovf_o), 8'h00);
        check(8'(udf_o), 8'h00);
        check(8'(crc_err_o), 8'h00);
        @(posedge ref_clk_i);
        run <= 1'b0;
        wait_cyc(300);
        check(exp_d, mdl.cnt);
        check(8'(udf_o), 8'h01);
    endtask

    // A corrupted check word is flagged, and the flag clears on request.
    task automatic t_bad_crc();
        do_reset(12'h7D0);
        bad <= 1'b1;
        chk_on <= 1'b1;
        run <= 1'b1;
        wait_cyc(4240);
        check(8'(crc_err_o), 8'h01);
        @(posedge ref_clk_i);
        err_clr_i <= 1'b1;
        bad <= 1'b0;
        wait_cyc(2);
        check(8'(crc_err_o), 8'h00);
        @(posedge ref_clk_i);
        err_clr_i <= 1'b0;
    endtask

    // A link twice as fast as the reader must overrun the FIFO.
    task automatic t_overrun();
        do_reset(12'h3E8);
        run <= 1'b1;
        wait_cyc(300);
        check(8'(ovf_o), 8'h01);
    endtask

    // Nominal, slow and fast link rates, then the fault cases.
    initial begin
        t_stream(12'h7D0);
        t_stream(12'h7DB);
        t_stream(12'h7C5);
        t_bad_crc();
        t_overrun();
        print_verdict();
    end
endmodule

/* File: rtl/rsf_pkg.sv */
// Constants for the receive synchronizing FIFO with rate matching.
package rsf_pkg;
    // Bit-times between periodic CRC slots and bit-times the slot takes.
    localparam int CRC_PERIOD = 516;
    localparam int CRC_LEN = 4;
    localparam int DATA_LEN = CRC_PERIOD - CRC_LEN;
    // Frequency tolerance: plain offset in ppm plus spread spectrum in ppm.
    localparam int FREQ_PPM = 600;
    localparam int SSC_PPM = 5000;
    // Clock periods in ns and the core cycles per link bit-time.
    localparam int CLK_NS = 50;
    localparam int LINK_BIT_NS = 400;
    localparam int TICK_CYC = LINK_BIT_NS / CLK_NS;
    // Words of drift between two slots, rounded up.
    localparam int DRIFT_WORDS = (CRC_PERIOD * (FREQ_PPM + SSC_PPM) + 999999) / 1000000;
    // Fill level the read side steers to and the dead band around it.
    localparam int TARGET_FILL = 4;
    localparam int FILL_TOL = 1;
    // Values after reset.
    localparam int RST_TICK = TICK_CYC - 1;
endpackage

/* File: rtl/rsf_sync_fifo.sv */
// Receive synchronizing FIFO moving link words into the core clock domain.
// Summary of operation
// - Every received data word crosses into core domain; slot words and words arriving while full do not.
// - Tolerate 600 ppm clock frequency difference.
// - Also tolerate 0.5 percent spread spectrum.
// - Read pointer follows measured receive clock phase.
// - Read rate can slow down and speed up.
// - CRC slot: 4 of every 516 bit-times.
// - Use the CRC slot to adjust reading.
// - Check CRC alongside data transfer.
// - Tracking error bounded by step and comparison.
`timescale 1ns/100ps
module rsf_sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Link side, asynchronous to ref_clk_i.
    input wire logic link_clk_i,
    input wire logic [WIDTH-1:0] link_data_i,
    // Core side.
    input wire logic err_clr_i,
    output logic [WIDTH-1:0] data_o,
    output logic valid_o,
    output logic ovf_o,
    output logic udf_o,
    output logic crc_err_o
);
    localparam int PW = $clog2(DEPTH) + 1;
    localparam int AW = $clog2(DEPTH);
    localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
    localparam logic [PW-1:0] HI_FILL = PW'(rsf_pkg::TARGET_FILL + rsf_pkg::FILL_TOL);
    localparam logic [PW-1:0] LO_FILL = PW'(rsf_pkg::TARGET_FILL - rsf_pkg::FILL_TOL);
    localparam logic [PW-1:0] GO_FILL = PW'(rsf_pkg::TARGET_FILL);
    localparam logic [9:0] SLOT_FIRST = 10'(rsf_pkg::DATA_LEN);
    localparam logic [9:0] SLOT_LAST = 10'(rsf_pkg::CRC_PERIOD - 1);
    localparam logic [4:0] TICK_LAST = 5'(rsf_pkg::RST_TICK);
    localparam logic [4:0] TICK_HOLD = 5'(2 * rsf_pkg::TICK_CYC - 1);

    // Words held between write and read pointer.
    function automatic logic [PW-1:0] fill_of(input logic [PW-1:0] w, input logic [PW-1:0] r);
        fill_of = w - r;
    endfunction

    logic [WIDTH-1:0] mem [DEPTH];
    logic lclk_s1_ff, lclk_s2_ff, lclk_s3_ff;
    logic [WIDTH-1:0] ldat_s1_ff, ldat_s2_ff;
    logic [9:0] bt_ff;
    logic [PW-1:0] wr_ff, rd_ff;
    logic [WIDTH-1:0] chk_ff;
    logic slot_go_ff, primed_ff;
    logic [4:0] tick_ff;
    logic link_edge, in_slot, full, rd_now;
    logic skip_ff, rd_skip, rd_go;
    logic [PW-1:0] fill;

    // Two-stage synchronisers; data is taken from the same stage as the clock.
    // Limitation: link data must be stable for two core cycles after its edge.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lclk_s1_ff <= 1'b0;
            lclk_s2_ff <= 1'b0;
            lclk_s3_ff <= 1'b0;
            ldat_s1_ff <= '0;
            ldat_s2_ff <= '0;
        end else begin
            lclk_s1_ff <= link_clk_i;
            lclk_s2_ff <= lclk_s1_ff;
            lclk_s3_ff <= lclk_s2_ff;
            ldat_s1_ff <= link_data_i;
            ldat_s2_ff <= ldat_s1_ff;
        end
    end

    assign link_edge = lclk_s2_ff & ~lclk_s3_ff;
    assign in_slot = (bt_ff >= SLOT_FIRST);
    assign fill = fill_of(wr_ff, rd_ff);
    assign full = (fill == DEPTH_P);
    assign rd_now = primed_ff && (tick_ff == 5'h00);
    // Below the target fill every other tick is given up on purpose, so the
    // spare read ticks of a slow link never run the FIFO dry.
    assign rd_skip = rd_now && (fill < GO_FILL) && !skip_ff;
    assign rd_go = rd_now && !rd_skip && (fill != '0);

    // Bit-time counter marks the periodic CRC slot.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bt_ff <= 10'h000;
        end else if (link_edge) begin
            bt_ff <= (bt_ff == SLOT_LAST) ? 10'h000 : bt_ff + 10'h001;
        end
    end

    // Data bit-times are written; slot bit-times never enter the FIFO.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ff <= '0;
        end else if (link_edge && !in_slot && !full) begin
            wr_ff <= wr_ff + PW'(1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (link_edge && !in_slot && !full) begin
            mem[wr_ff[AW-1:0]] <= ldat_s2_ff;
        end
    end

    // Running check value folded over the data, compared in the first slot word.
    // Checking runs in parallel, so the slot time is free for draining.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chk_ff <= '0;
        end else if (link_edge) begin
            if (!in_slot) begin
                chk_ff <= chk_ff ^ ldat_s2_ff;
            end else if (bt_ff == SLOT_LAST) begin
                chk_ff <= '0;
            end
        end
    end

    // One-cycle marker at the start of each slot steers the read side.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            slot_go_ff <= 1'b0;
        end else begin
            slot_go_ff <= link_edge && (bt_ff == SLOT_FIRST);
        end
    end

    // Reading starts once the target fill is first reached.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            primed_ff <= 1'b0;
        end else if (fill >= GO_FILL) begin
            primed_ff <= 1'b1;
        end
    end

    // Read tick at the nominal bit rate; at each slot the fill level, which
    // measures receive phase against core phase, ends the current tick at once
    // or reloads it a whole word longer. A one-word step keeps latency error small while
    // drift per slot stays under the slot length.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tick_ff <= TICK_LAST;
        end else if (slot_go_ff && primed_ff && fill > HI_FILL) begin
            tick_ff <= 5'h00;
        end else if (slot_go_ff && primed_ff && fill < LO_FILL) begin
            tick_ff <= TICK_HOLD;
        end else if (tick_ff == 5'h00) begin
            tick_ff <= TICK_LAST;
        end else begin
            tick_ff <= tick_ff - 5'h01;
        end
    end

    // Remembers whether the last tick was given up; two skips in a row would
    // stall a drain that has fewer words left than the target fill.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            skip_ff <= 1'b0;
        end else if (rd_now) begin
            skip_ff <= rd_skip;
        end
    end

    // Read pointer and output word.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_ff <= '0;
            data_o <= '0;
            valid_o <= 1'b0;
        end else begin
            valid_o <= rd_go;
            if (rd_go) begin
                rd_ff <= rd_ff + PW'(1);
                data_o <= mem[rd_ff[AW-1:0]];
            end
        end
    end

    // Sticky error flags; a new event wins over a clear in the same cycle.
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ovf_o <= 1'b0;
            udf_o <= 1'b0;
            crc_err_o <= 1'b0;
        end else begin
            ovf_o <= (link_edge && !in_slot && full) || (ovf_o && !err_clr_i);
            udf_o <= (rd_now && !rd_skip && fill == '0) || (udf_o && !err_clr_i);
            crc_err_o <= (link_edge && bt_ff == SLOT_FIRST && ldat_s2_ff != chk_ff)
                || (crc_err_o && !err_clr_i);
        end
    end

    property p_slot_no_write;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        in_slot |=> wr_ff == $past(wr_ff);
    endproperty
    a_slot_no_write: assert property (p_slot_no_write) else $error("write in CRC slot");

    property p_write;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        link_edge && !in_slot && !full |=> wr_ff == $past(wr_ff) + PW'(1);
    endproperty
    a_write: assert property (p_write) else $error("data word not written");

    property p_wrap;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        link_edge && bt_ff == SLOT_LAST |=> bt_ff == 10'h000 ##1 bt_ff == 10'h000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("slot period wrong");

    property p_valid;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        valid_o |-> rd_ff == $past(rd_ff) + PW'(1);
    endproperty
    a_valid: assert property (p_valid) else $error("valid without read");

    property p_speed;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        slot_go_ff && primed_ff && fill > HI_FILL |=> tick_ff == 5'h00 ##1 tick_ff == TICK_LAST;
    endproperty
    a_speed: assert property (p_speed) else $error("no speed-up");

    property p_slow;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        slot_go_ff && primed_ff && fill < LO_FILL |=> tick_ff == TICK_HOLD;
    endproperty
    a_slow: assert property (p_slow) else $error("no slow-down");

    property p_ovf;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        link_edge && !in_slot && full |=> ovf_o && $stable(wr_ff);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overrun not flagged");

    property p_udf;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_now && !rd_skip && fill == '0 |=> udf_o && !valid_o;
    endproperty
    a_udf: assert property (p_udf) else $error("underrun not flagged");

    property p_skip;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rd_skip |=> !valid_o && $stable(rd_ff);
    endproperty
    a_skip: assert property (p_skip) else $error("read taken on a skipped tick");

    property p_bound;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        fill <= DEPTH_P;
    endproperty
    a_bound: assert property (p_bound) else $error("fill out of range");

    property p_crc;
        @(posedge ref_clk_i) disable iff (!rstn_i)
        link_edge && bt_ff == SLOT_FIRST && ldat_s2_ff != chk_ff |=> crc_err_o;
    endproperty
    a_crc: assert property (p_crc) else $error("CRC mismatch missed");
endmodule
